/* verilog/gpsc_gpio_pins.sv */
// Notes on behaviour
// - read-only seven-bit status returns live pin levels at read time, gated by input allow (a disabled pin reads zero).
// - pin n level appears in status bit n.
// - one input-allow bit per pin, bits 6..0, resets to enabled.
// - bits 4..2 of drive control pick the output data origin.
// - bits 7..5 of drive control pick the data the origin delivers.
// - origin 100 with choice 000 drives the register-held level bit 1.
// - every drive-control field resets to zero, drivers off.
// - pins 0..6 have identical drive-control registers at 0x10..0x16.
`timescale 1ns/1ps

// input side of one pin: its input allow bit and the gated level it reports
module gpsc_pin_sense #(
    parameter int unsigned PIN_INDEX = 0
) (
    input  wire logic i_clock,
    input  wire logic i_resetn,
    input  wire logic i_allow_hit,
    input  wire logic i_allow_wdata,
    input  wire logic i_pin,
    output logic      o_input_allow,
    output logic      o_live_level
);

    logic input_allow_reg;
    logic input_allow_next;

    assign input_allow_next = i_allow_hit ? i_allow_wdata : input_allow_reg;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            input_allow_reg <= gpsc_pkg::GPSC_INPUT_ALLOW_RESET[PIN_INDEX];
        end else begin
            input_allow_reg <= input_allow_next;
        end
    end

    // a disabled input reports zero rather than whatever floats on the pad
    assign o_live_level  = i_pin & input_allow_reg;
    assign o_input_allow = input_allow_reg;

endmodule : gpsc_pin_sense

// output side of one pin: its drive-control byte and the pad it steers
module gpsc_pin_drive (
    input  wire logic       i_clock,
    input  wire logic       i_resetn,
    input  wire logic       i_drive_hit,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_origin_data,
    output logic      [7:0] o_control,
    output logic            o_pin,
    output logic            o_pin_oe
);

    logic      [7:0] control_reg;
    logic      [7:0] control_next;
    wire logic [2:0] origin;
    wire logic [2:0] choice;
    wire logic       level;
    wire logic       allow;
    wire logic       use_level;
    wire logic       drive_value;

    // a write replaces the whole byte; every bit of it is software-owned
    assign control_next = i_drive_hit ? i_wdata : control_reg;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            control_reg <= gpsc_pkg::GPSC_DRIVE_CONTROL_RESET;
        end else begin
            control_reg <= control_next;
        end
    end

    assign origin      = control_reg[gpsc_pkg::GPSC_DRV_ORIGIN_MSB:
                                     gpsc_pkg::GPSC_DRV_ORIGIN_LSB];
    assign choice      = control_reg[gpsc_pkg::GPSC_DRV_CHOICE_MSB:
                                     gpsc_pkg::GPSC_DRV_CHOICE_LSB];
    assign level       = control_reg[gpsc_pkg::GPSC_DRV_LEVEL_BIT];
    assign allow       = control_reg[gpsc_pkg::GPSC_DRV_ALLOW_BIT];
    assign use_level   = (origin == gpsc_pkg::GPSC_ORIGIN_REGISTER) &&
                         (choice == gpsc_pkg::GPSC_CHOICE_REGISTER);
    // other origins are not built here; they arrive from outside on i_origin_data
    assign drive_value = use_level ? level : i_origin_data;

    // value held low while released, so nothing stale shows on the pad
    assign o_pin     = allow & drive_value;
    // no interlock with input allow: software keeps the two exclusive
    assign o_pin_oe  = allow;
    assign o_control = control_reg;

endmodule : gpsc_pin_drive

// register front end: decodes the byte address and routes strobes to the pin slices
module gpsc_gpio_pins (
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_write,
    input  wire logic        i_read,
    output logic      [7:0]  o_rdata,
    input  wire logic [6:0]  i_pin,
    output logic      [6:0]  o_pin,
    output logic      [6:0]  o_pin_oe,
    input  wire logic [6:0]  i_origin_data,
    output logic      [6:0]  o_pin_level_readback
);

    logic      [7:0] rdata_reg;
    logic      [7:0] rdata_next;
    wire logic [7:0] drive_control [0:6];
    wire logic [6:0] input_allow;
    wire logic [6:0] live_level;
    wire logic       sel_status;
    wire logic       sel_inen;
    wire logic [6:0] sel_drive;
    wire logic       sel_any_drive;
    wire logic       inen_hit;
    wire logic [6:0] inen_wdata;
    wire logic [6:0] drive_hit;
    wire logic [7:0] status_byte;
    wire logic [7:0] inen_byte;
    wire logic [7:0] drive_read [0:6];
    wire logic [7:0] drive_byte;
    wire logic [7:0] unmapped_byte;
    wire logic [7:0] rd_mux;

    // one named select per register; anything else decodes to nothing
    assign sel_status    = (i_addr == gpsc_pkg::GPSC_PIN_LEVEL_STATUS_OFS);
    assign sel_inen      = (i_addr == gpsc_pkg::GPSC_PIN_INPUT_ENABLES_OFS);
    assign sel_drive[0]  = (i_addr == gpsc_pkg::GPSC_PIN0_DRIVE_CONTROL_OFS);
    assign sel_drive[1]  = (i_addr == gpsc_pkg::GPSC_PIN1_DRIVE_CONTROL_OFS);
    assign sel_drive[2]  = (i_addr == gpsc_pkg::GPSC_PIN2_DRIVE_CONTROL_OFS);
    assign sel_drive[3]  = (i_addr == gpsc_pkg::GPSC_PIN3_DRIVE_CONTROL_OFS);
    assign sel_drive[4]  = (i_addr == gpsc_pkg::GPSC_PIN4_DRIVE_CONTROL_OFS);
    assign sel_drive[5]  = (i_addr == gpsc_pkg::GPSC_PIN5_DRIVE_CONTROL_OFS);
    assign sel_drive[6]  = (i_addr == gpsc_pkg::GPSC_PIN6_DRIVE_CONTROL_OFS);
    assign sel_any_drive = |sel_drive;

    // status has no write hit at all, so writes to it are dropped
    assign inen_hit      = i_write && sel_inen;
    assign drive_hit     = {7{i_write}} & sel_drive;
    assign inen_wdata    = i_wdata[6:0];

    // reserved bit 7 of status and input enables always reads zero
    assign status_byte   = {1'b0, live_level};
    assign inen_byte     = {1'b0, input_allow};
    assign drive_read[0] = sel_drive[0] ? drive_control[0] : 8'h00;
    assign drive_read[1] = sel_drive[1] ? drive_control[1] : 8'h00;
    assign drive_read[2] = sel_drive[2] ? drive_control[2] : 8'h00;
    assign drive_read[3] = sel_drive[3] ? drive_control[3] : 8'h00;
    assign drive_read[4] = sel_drive[4] ? drive_control[4] : 8'h00;
    assign drive_read[5] = sel_drive[5] ? drive_control[5] : 8'h00;
    assign drive_read[6] = sel_drive[6] ? drive_control[6] : 8'h00;
    // selects are one-hot, so the drive bytes can simply be ORed
    assign drive_byte    = drive_read[0] | drive_read[1] | drive_read[2] |
                           drive_read[3] | drive_read[4] | drive_read[5] |
                           drive_read[6];
    assign unmapped_byte = 8'h00;
    assign rd_mux        = sel_status    ? status_byte :
                           sel_inen      ? inen_byte :
                           sel_any_drive ? drive_byte :
                                           unmapped_byte;
    // data stands for the one cycle after the strobe only, zero elsewhere
    assign rdata_next    = i_read ? rd_mux : 8'h00;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata              = rdata_reg;
    assign o_pin_level_readback = live_level;

    // input side, one slice per pin
    gpsc_pin_sense #(
        .PIN_INDEX(0)
    ) u_sense0 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_allow_hit   (inen_hit),
        .i_allow_wdata (inen_wdata[0]),
        .i_pin         (i_pin[0]),
        .o_input_allow (input_allow[0]),
        .o_live_level  (live_level[0])
    );

    gpsc_pin_sense #(
        .PIN_INDEX(1)
    ) u_sense1 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_allow_hit   (inen_hit),
        .i_allow_wdata (inen_wdata[1]),
        .i_pin         (i_pin[1]),
        .o_input_allow (input_allow[1]),
        .o_live_level  (live_level[1])
    );

    gpsc_pin_sense #(
        .PIN_INDEX(2)
    ) u_sense2 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_allow_hit   (inen_hit),
        .i_allow_wdata (inen_wdata[2]),
        .i_pin         (i_pin[2]),
        .o_input_allow (input_allow[2]),
        .o_live_level  (live_level[2])
    );

    gpsc_pin_sense #(
        .PIN_INDEX(3)
    ) u_sense3 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_allow_hit   (inen_hit),
        .i_allow_wdata (inen_wdata[3]),
        .i_pin         (i_pin[3]),
        .o_input_allow (input_allow[3]),
        .o_live_level  (live_level[3])
    );

    gpsc_pin_sense #(
        .PIN_INDEX(4)
    ) u_sense4 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_allow_hit   (inen_hit),
        .i_allow_wdata (inen_wdata[4]),
        .i_pin         (i_pin[4]),
        .o_input_allow (input_allow[4]),
        .o_live_level  (live_level[4])
    );

    gpsc_pin_sense #(
        .PIN_INDEX(5)
    ) u_sense5 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_allow_hit   (inen_hit),
        .i_allow_wdata (inen_wdata[5]),
        .i_pin         (i_pin[5]),
        .o_input_allow (input_allow[5]),
        .o_live_level  (live_level[5])
    );

    gpsc_pin_sense #(
        .PIN_INDEX(6)
    ) u_sense6 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_allow_hit   (inen_hit),
        .i_allow_wdata (inen_wdata[6]),
        .i_pin         (i_pin[6]),
        .o_input_allow (input_allow[6]),
        .o_live_level  (live_level[6])
    );

    // output side, one slice per pin
    gpsc_pin_drive u_drive0 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_drive_hit   (drive_hit[0]),
        .i_wdata       (i_wdata),
        .i_origin_data (i_origin_data[0]),
        .o_control     (drive_control[0]),
        .o_pin         (o_pin[0]),
        .o_pin_oe      (o_pin_oe[0])
    );

    gpsc_pin_drive u_drive1 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_drive_hit   (drive_hit[1]),
        .i_wdata       (i_wdata),
        .i_origin_data (i_origin_data[1]),
        .o_control     (drive_control[1]),
        .o_pin         (o_pin[1]),
        .o_pin_oe      (o_pin_oe[1])
    );

    gpsc_pin_drive u_drive2 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_drive_hit   (drive_hit[2]),
        .i_wdata       (i_wdata),
        .i_origin_data (i_origin_data[2]),
        .o_control     (drive_control[2]),
        .o_pin         (o_pin[2]),
        .o_pin_oe      (o_pin_oe[2])
    );

    gpsc_pin_drive u_drive3 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_drive_hit   (drive_hit[3]),
        .i_wdata       (i_wdata),
        .i_origin_data (i_origin_data[3]),
        .o_control     (drive_control[3]),
        .o_pin         (o_pin[3]),
        .o_pin_oe      (o_pin_oe[3])
    );

    gpsc_pin_drive u_drive4 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_drive_hit   (drive_hit[4]),
        .i_wdata       (i_wdata),
        .i_origin_data (i_origin_data[4]),
        .o_control     (drive_control[4]),
        .o_pin         (o_pin[4]),
        .o_pin_oe      (o_pin_oe[4])
    );

    gpsc_pin_drive u_drive5 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_drive_hit   (drive_hit[5]),
        .i_wdata       (i_wdata),
        .i_origin_data (i_origin_data[5]),
        .o_control     (drive_control[5]),
        .o_pin         (o_pin[5]),
        .o_pin_oe      (o_pin_oe[5])
    );

    gpsc_pin_drive u_drive6 (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_drive_hit   (drive_hit[6]),
        .i_wdata       (i_wdata),
        .i_origin_data (i_origin_data[6]),
        .o_control     (drive_control[6]),
        .o_pin         (o_pin[6]),
        .o_pin_oe      (o_pin_oe[6])
    );

endmodule : gpsc_gpio_pins

/* verilog/gpsc_pkg.sv */
package gpsc_pkg;

    localparam int unsigned GPSC_NUM_PINS = 7;
    localparam int unsigned GPSC_ADDR_W   = 8;
    localparam int unsigned GPSC_DATA_W   = 8;

    // register offsets
    localparam logic [7:0] GPSC_PIN_LEVEL_STATUS_OFS  = 8'h0e;
    localparam logic [7:0] GPSC_PIN_INPUT_ENABLES_OFS = 8'h0f;
    localparam logic [7:0] GPSC_PIN0_DRIVE_CONTROL_OFS = 8'h10;
    localparam logic [7:0] GPSC_PIN1_DRIVE_CONTROL_OFS = 8'h11;
    localparam logic [7:0] GPSC_PIN2_DRIVE_CONTROL_OFS = 8'h12;
    localparam logic [7:0] GPSC_PIN3_DRIVE_CONTROL_OFS = 8'h13;
    localparam logic [7:0] GPSC_PIN4_DRIVE_CONTROL_OFS = 8'h14;
    localparam logic [7:0] GPSC_PIN5_DRIVE_CONTROL_OFS = 8'h15;
    localparam logic [7:0] GPSC_PIN6_DRIVE_CONTROL_OFS = 8'h16;

    // drive-control field positions
    localparam int unsigned GPSC_DRV_ALLOW_BIT  = 0;
    localparam int unsigned GPSC_DRV_LEVEL_BIT  = 1;
    localparam int unsigned GPSC_DRV_ORIGIN_LSB = 2;
    localparam int unsigned GPSC_DRV_ORIGIN_MSB = 4;
    localparam int unsigned GPSC_DRV_CHOICE_LSB = 5;
    localparam int unsigned GPSC_DRV_CHOICE_MSB = 7;

    // origin/choice pair that selects the register-held level
    localparam logic [2:0] GPSC_ORIGIN_REGISTER = 3'h4;
    localparam logic [2:0] GPSC_CHOICE_REGISTER = 3'h0;

    // reset values
    localparam logic [6:0] GPSC_INPUT_ALLOW_RESET   = 7'h7f;
    localparam logic [7:0] GPSC_DRIVE_CONTROL_RESET = 8'h00;

endpackage : gpsc_pkg

/* tb/gpsc_board.sv */
`timescale 1ns/1ps
module gpsc_board (
    input  wire logic [6:0] i_d,
    input  wire logic [6:0] i_en,
    input  wire logic [6:0] i_f,
    output logic      [6:0] o_lvl
);
    assign o_lvl = (i_d & i_en) | (i_f & ~i_en); // released pins show the board level, not the last driven one
endmodule : gpsc_board

/* tb/gpsc_chk.sv */
`timescale 1ns/1ps
module gpsc_chk (
    input wire logic       i_clock,
    input wire logic       i_resetn,
    input wire logic       i_write,
    input wire logic       i_read,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic [6:0] i_pin,
    input wire logic [6:0] o_pin,
    input wire logic [6:0] o_pin_oe,
    input wire logic [6:0] i_origin_data,
    input wire logic [6:0] o_pin_level_readback
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    wire [6:0] lv = o_pin_level_readback;
    wire w0 = i_write && i_addr == 8'h10, w6 = i_write && i_addr == 8'h16;
    wire ws = i_write && i_addr == 8'h0e, rs = i_read && i_addr == 8'h0e;
    wire wv = w0 && i_wdata[0] && i_wdata[7:2] == 6'h04;
    wire wo = w0 && i_wdata[0] && i_wdata[7:2] != 6'h04;
    a_rd_idle: assert property (!$past(i_read) |-> !o_rdata) else $error("rdata idle");
    a_sts_rd: assert property (rs |=> o_rdata == $past(lv)) else $error("status");
    a_oe_off: assert property (!(o_pin & ~o_pin_oe)) else $error("released");
    a_oe_six: assert property (w6 |=> o_pin_oe[6] == $past(i_wdata[0])) else $error("oe");
    a_reg_lvl: assert property (wv |=> o_pin[0] == $past(i_wdata[1])) else $error("level");
    a_org_pass: assert property (wo |=> o_pin[0] == i_origin_data[0]) else $error("src");
    a_sts_ro: assert property (ws |=> $stable(o_pin_oe)) else $error("read only");
    a_rst_off: assert property ($rose(i_resetn) |-> !o_pin_oe) else $error("reset");
endmodule : gpsc_chk
bind gpsc_gpio_pins gpsc_chk u_chk (.*);

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic c = 0, n = 0, w = 0, r = 0;
    logic [7:0] ad = 0, wd = 0, q, a, d, e, m [7] = '{7{8'h00}};
    logic [6:0] p, op, oe, og = 0, ex = 0, rb, ie = 7'h7f;
    logic [31:0] s = 32'h1011;
    int err_count = 0, checked = 0, cy = 0;
    always #12.5 c = ~c;
    gpsc_gpio_pins dut (.i_clock(c), .i_resetn(n), .i_addr(ad), .i_wdata(wd), .i_write(w),
        .i_read(r), .o_rdata(q), .i_pin(p), .o_pin(op), .o_pin_oe(oe), .i_origin_data(og),
        .o_pin_level_readback(rb));
    gpsc_board brd (.i_d(op), .i_en(oe), .i_f(ex), .o_lvl(p));
    function automatic logic [6:0] lv;
        for (int i = 0; i < 7; i++) lv[i] = !m[i][0] ? ex[i] : m[i][7:2] == 6'h04 ? m[i][1] : og[i];
    endfunction : lv
    function automatic logic [6:0] oem;
        for (int i = 0; i < 7; i++) oem[i] = m[i][0];
    endfunction : oem
    function automatic logic [6:0] opm;
        for (int i = 0; i < 7; i++) opm[i] = m[i][0] & (m[i][7:2] == 6'h04 ? m[i][1] : og[i]);
    endfunction : opm
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13; x ^= x >> 17; return x ^ x << 5;
    endfunction : xs
    task automatic chk(string t, logic [7:0] v, logic [7:0] x);
        checked++; if (v !== x) begin err_count++; $display("mismatch %s exp %h saw %h", t, x, v); end
    endtask : chk
    task automatic wr(logic [7:0] k, logic [7:0] v);
        @(posedge c) {ad, wd, w} <= {k, v, 1'b1};
        @(posedge c) w <= 0;
        if (k == 8'h0f) ie = v[6:0]; else if (k > 8'h0f && k < 8'h17) m[k[2:0]] = v;
    endtask : wr
    task automatic rd(logic [7:0] k);
        @(posedge c) {ad, r} <= {k, 1'b1};
        #1 e = k == 8'h0e ? {1'b0, lv() & ie} : k == 8'h0f ? {1'b0, ie} : 8'h00;
        if (k > 8'h0f && k < 8'h17) e = m[k[2:0]];
        @(posedge c) r <= 0;
        #1 chk("rdata", q, e);
        chk("readback", {1'b0, rb}, {1'b0, lv() & ie});
        chk("drive_allow", {1'b0, oe}, {1'b0, oem()});
        chk("pin_out", {1'b0, op}, {1'b0, opm()});
    endtask : rd
    task automatic end_of_test;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge c) if (++cy == 9000) begin err_count++; end_of_test(); end
    initial begin
        repeat (4) @(posedge c);
        n <= 1;
        for (int i = 14; i < 24; i++) rd(8'(i));
        repeat (300) begin
            s = xs(s); a = 8'h0e + 8'(s[3:0] % 10);
            @(posedge c) {og, ex} <= s[30:17];
            d = s[16] ? {6'h04, s[9:8]} : s[15:8];
            if (a == 8'h0f) d &= {1'b1, ~oem()};
            if (a > 8'h0f && a < 8'h17 && d[0]) wr(8'h0f, ie & ~(8'h01 << a[2:0]));
            wr(a, d); rd(a); rd(8'h0e);
        end
        end_of_test();
    end
endmodule : testbench
